//--- divr_pkg.sv
// Package for the interrupt vectoring and reset block.
// Assumes one instruction-rate clock and synchronous active-high reset.
package divr_pkg;
   localparam int unsigned DIVR_NUM_SRC = 8;
   localparam int unsigned DIVR_VEC_W = 14;
   localparam logic [13:0] DIVR_VEC_RESET = 14'h0000;
   // Vector tables, index 0 = highest priority source
   localparam logic [13:0] DIVR_VEC_HOST [0:7] = '{14'h0004, 14'h0008,
      14'h000C, 14'h0010, 14'h0014, 14'h0018, 14'h001C, 14'h0020};
   localparam logic [13:0] DIVR_VEC_DUAL [0:7] = '{14'h0004, 14'h0008,
      14'h000C, 14'h0010, 14'h0014, 14'h0018, 14'h0000, 14'h0000};
   // Source index, host variant
   localparam int unsigned DIVR_SRC_EXT2 = 0;
   localparam int unsigned DIVR_SRC_HWR = 1;
   localparam int unsigned DIVR_SRC_HRD = 2;
   localparam int unsigned DIVR_SRC_P0TX = 3;
   localparam int unsigned DIVR_SRC_P0RX = 4;
   localparam int unsigned DIVR_SRC_P1TX = 5;
   localparam int unsigned DIVR_SRC_P1RX = 6;
   localparam int unsigned DIVR_SRC_TIMER = 7;
   localparam int unsigned DIVR_NEST_BIT = 4;
   localparam int unsigned DIVR_CTL_W = 5;
   localparam int unsigned DIVR_STACK_DEPTH = 9;
   localparam int unsigned DIVR_STAT_W = 16;
   localparam int unsigned DIVR_PLL_LOCK_CYC = 2000;
   typedef enum logic [1:0]
   {
      DIVR_RUN = 2'b00,
      DIVR_TAKE = 2'b01
   } divr_state_e;
endpackage

//--- divr_pin_if.sv
// Interface carrying the serial port one pin group between pin mux and core.
// Assumes the top module drives the raw pins into it.
`timescale 1ns/1ns
interface divr_pin_if;
   logic rfs;
   logic tfs;
   logic drx;
   logic dtx;
   logic alt_cfg;
   logic req0;
   logic req1;
   logic flag_in;
   logic flag_out;
   logic dtx_port;
   modport mux (input rfs, tfs, drx, alt_cfg, flag_out, dtx_port,
                output req0, req1, flag_in, dtx);
   modport core (output rfs, tfs, drx, alt_cfg, flag_out, dtx_port,
                 input req0, req1, flag_in, dtx);
endinterface

//--- divr_pin_mux.sv
// Pin sharing for serial port one: port pins or requests and flags.
// Assumes pins are synchronous to the clock.
`timescale 1ns/1ns
module divr_pin_mux
(
   divr_pin_if.mux pins  // Pin group
);
   // Requests are active low on the pins; held inactive (0) in port mode
   assign pins.req0 = pins.alt_cfg & ~pins.rfs;
   assign pins.req1 = pins.alt_cfg & ~pins.tfs;
   assign pins.flag_in = pins.alt_cfg & pins.drx;
   assign pins.dtx = pins.alt_cfg ? pins.flag_out : pins.dtx_port;
endmodule

//--- divr_top.sv
// Interrupt vectoring, priority, status stack and pin configuration.
// Assumes the sequencer acknowledges a presented vector with ack_i.
`timescale 1ns/1ns
module divr_top
#(
   parameter bit HOST_VARIANT = 1'b1  // 1: host mailbox variant
)
(
   input wire logic clk_i,  // Instruction-rate clock
   input wire logic sys_rst_i,  // Synchronous reset, high
   input wire logic alt_cfg_i,  // 1: port one pins are requests/flags
   input wire logic ext_req_two_n_i,  // External request two, low
   input wire logic p1_rfs_i,  // Port one receive frame sync pin
   input wire logic p1_tfs_i,  // Port one transmit frame sync pin
   input wire logic p1_drx_i,  // Port one receive data pin
   input wire logic p1_dtx_port_i,  // Port one transmit data from port
   input wire logic flag_out_i,  // Flag output value from core
   input wire logic [7:0] periph_req_i,  // Internal requests by index
   input wire logic [7:0] mask_wr_i,  // Mask write value
   input wire logic mask_we_i,  // Mask write strobe
   input wire logic [4:0] ctl_wr_i,  // Control register write value
   input wire logic ctl_we_i,  // Control write strobe
   input wire logic [15:0] arith_stat_i,  // Arithmetic status to push
   input wire logic [15:0] mode_stat_wr_i,  // Mode status write value
   input wire logic mode_stat_we_i,  // Mode status write strobe
   input wire logic ack_i,  // Sequencer takes presented vector
   input wire logic rti_i,  // Return from interrupt, pops stack
   output logic irq_pend_o,  // A vector is presented
   output logic [13:0] vector_o,  // Vector for the sequencer
   output logic [7:0] mask_o,  // Interrupt mask register
   output logic [15:0] mode_stat_o,  // Mode status register
   output logic [15:0] arith_pop_o,  // Arithmetic status popped
   output logic stack_empty_o,  // Status stack empty
   output logic stack_full_o,  // Status stack full
   output logic p1_dtx_o,  // Port one transmit data pin
   output logic flag_in_o,  // Flag input value
   output logic clk_out_o  // Clock output, toggles every cycle (one period per two cycles)
);
   import divr_pkg::*;

   // ****************************************
   // Pin sharing
   // ****************************************
   divr_pin_if pins ();
   assign pins.rfs = p1_rfs_i;
   assign pins.tfs = p1_tfs_i;
   assign pins.drx = p1_drx_i;
   assign pins.alt_cfg = alt_cfg_i;
   assign pins.flag_out = flag_out_i;
   assign pins.dtx_port = p1_dtx_port_i;
   divr_pin_mux u_mux (.pins(pins));

   // ****************************************
   // Request gathering and priority
   // ****************************************
   logic [7:0] mask_r;
   logic [4:0] ctl_r;
   logic [15:0] mode_r;
   logic [7:0] raw_req;
   logic [7:0] eff_req;
   logic [7:0] masked;
   logic [2:0] win_idx;
   logic any_win;
   logic [3:0] sp_r;
   logic [3:0] sp_nxt;
   logic active;
   logic nest_en;
   logic allow;
   logic [13:0] win_vec;
   divr_state_e st_r;
   logic pend_r;
   logic [13:0] vec_r;
   logic [15:0] pop_r;
   logic dtx_r;
   logic fi_r;
   logic clk_r;
   logic empty_r;
   logic full_r;
   logic [39:0] stk [0:DIVR_STACK_DEPTH-1];

   function automatic logic [2:0] prio_idx(input logic [7:0] r);
      logic [2:0] k;
      k = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (r[i])
            k = 3'(i);
      end
      return k;
   endfunction

   // Port one sources are its interrupts or the alternate requests
   assign raw_req[0] = ~ext_req_two_n_i;
   assign raw_req[7:1] = periph_req_i[7:1];
   // Dual variant lacks host sources: indices shift down by two
   assign eff_req = HOST_VARIANT ? {raw_req[7],
      raw_req[6] | pins.req0, raw_req[5] | pins.req1, raw_req[4:0]}
      : {2'b00, raw_req[7], raw_req[6] | pins.req0,
         raw_req[5] | pins.req1, raw_req[4:3], raw_req[0]};
   assign masked = eff_req & mask_r;
   assign any_win = |masked;
   assign win_idx = prio_idx(masked);
   assign win_vec = HOST_VARIANT ? DIVR_VEC_HOST[win_idx]
      : DIVR_VEC_DUAL[win_idx];
   assign active = (sp_r != 4'h0);
   assign nest_en = ctl_r[DIVR_NEST_BIT];
   // Without nesting only one routine may be active
   assign allow = nest_en ? 1'b1 : ~active;
   assign sp_nxt = (st_r == DIVR_TAKE && ack_i) ? sp_r + 4'h1
      : (rti_i && active) ? sp_r - 4'h1 : sp_r;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mask_r <= 8'h00;
         ctl_r <= 5'h00;
         mode_r <= 16'h0000;
         sp_r <= 4'h0;
         empty_r <= 1'b1;
         full_r <= 1'b0;
      end
      else
      begin
         sp_r <= sp_nxt;
         empty_r <= (sp_nxt == 4'h0);
         full_r <= (sp_nxt == 4'(DIVR_STACK_DEPTH));
         if (mask_we_i)
            mask_r <= mask_wr_i;
         else if (rti_i && active)
            mask_r <= stk[sp_r - 4'h1][7:0];
         if (ctl_we_i)
            ctl_r <= ctl_wr_i;
         if (mode_stat_we_i)
            mode_r <= mode_stat_wr_i;
         else if (rti_i && active)
            mode_r <= stk[sp_r - 4'h1][23:8];
      end
   end

   // Stack array holds no reset; pointer reset empties it
   always_ff @(posedge clk_i)
   begin
      if (!sys_rst_i && st_r == DIVR_TAKE && ack_i)
         stk[sp_r] <= {arith_stat_i, mode_r, mask_r};
   end

   // ****************************************
   // Vector presentation
   // ****************************************
   // A full stack blocks further taking rather than overwrite status
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st_r <= DIVR_RUN;
         pend_r <= 1'b0;
         vec_r <= DIVR_VEC_RESET;
         pop_r <= 16'h0000;
      end
      else
      begin
         unique case (st_r)
            DIVR_RUN:
            begin
               if (any_win && allow && sp_r < 4'(DIVR_STACK_DEPTH))
               begin
                  st_r <= DIVR_TAKE;
                  pend_r <= 1'b1;
                  vec_r <= win_vec;
               end
            end
            DIVR_TAKE:
            begin
               if (ack_i)
               begin
                  st_r <= DIVR_RUN;
                  pend_r <= 1'b0;
               end
               else if (any_win)
                  vec_r <= win_vec;
            end
            default:
               st_r <= DIVR_RUN;
         endcase
         if (rti_i && active)
            pop_r <= stk[sp_r - 4'h1][39:24];
      end
   end

   // ****************************************
   // Pins and clock output
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         dtx_r <= 1'b0;
         fi_r <= 1'b0;
      end
      else
      begin
         dtx_r <= pins.dtx;
         fi_r <= pins.flag_in;
      end
   end

   // Keeps toggling in reset: the clock does not stop for a reset.
   // No reset and no initial value: an unknown start settles in one edge
   always_ff @(posedge clk_i)
   begin
      if (clk_r)
         clk_r <= 1'b0;
      else
         clk_r <= 1'b1;
   end

   assign irq_pend_o = pend_r;
   assign vector_o = vec_r;
   assign mask_o = mask_r;
   assign mode_stat_o = mode_r;
   assign arith_pop_o = pop_r;
   assign stack_empty_o = empty_r;
   assign stack_full_o = full_r;
   assign p1_dtx_o = dtx_r;
   assign flag_in_o = fi_r;
   assign clk_out_o = clk_r;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_take;
      st_r == DIVR_RUN && any_win && allow && !stack_full_o;
   endsequence

   chk_take_presents: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_take |=> irq_pend_o)
      else $error("request not presented");
   chk_masked_idle: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st_r == DIVR_RUN && masked == 8'h00 |=> !irq_pend_o)
      else $error("masked request presented");
   chk_nest_off: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      st_r == DIVR_RUN && !nest_en && active |=> !irq_pend_o)
      else $error("nested while nesting off");
   chk_push_depth: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      irq_pend_o && ack_i && !rti_i |=> sp_r == $past(sp_r) + 4'h1)
      else $error("stack not pushed");
   chk_reset_state: assert property (
      @(posedge clk_i) $fell(sys_rst_i) |->
      mask_r == 8'h00 && sp_r == 4'h0 && mode_r == 16'h0000)
      else $error("reset state wrong");
   chk_vec_host: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_take and (HOST_VARIANT && masked == 8'h80) |=>
      vector_o == 14'h0020)
      else $error("timer vector wrong");
   chk_vec_dual: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_take and (!HOST_VARIANT && masked == 8'h20) |=>
      vector_o == 14'h0018)
      else $error("dual timer vector wrong");
   chk_alt_pins: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      alt_cfg_i |=> p1_dtx_o == $past(flag_out_i))
      else $error("flag output not on pin");
   chk_clk_out: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      1'b1 |=> clk_out_o != $past(clk_out_o))
      else $error("clock output stalled");
endmodule

//--- divr_seq_model.sv
// Sequencer model: takes a presented vector after a set delay.
// Assumes the block's clock and synchronous active-high reset.
`timescale 1ns/1ns
module divr_seq_model
(
   input wire logic clk_i,  // Clock
   input wire logic sys_rst_i,  // Reset, high
   input wire logic pend_i,  // Vector presented
   input wire logic [13:0] vec_i,  // Presented vector
   input wire logic [1:0] lat_i,  // Cycles before acknowledge
   output logic ack_o,  // Takes the vector
   output logic [13:0] vec_o,  // Vector last taken
   output logic [7:0] cnt_o  // Vectors taken
);
   logic [1:0] wait_r;
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ack_o <= 1'b0;
         wait_r <= 2'h0;
         vec_o <= 14'h0000;
         cnt_o <= 8'h00;
      end
      else if (ack_o)
      begin
         // Vector is read at the same edge that sees the acknowledge
         ack_o <= 1'b0;
         vec_o <= vec_i;
         cnt_o <= cnt_o + 8'h01;
         wait_r <= 2'h0;
      end
      else if (pend_i)
      begin
         ack_o <= (wait_r == lat_i);
         wait_r <= wait_r + 2'h1;
      end
      else
         wait_r <= 2'h0;
   end
endmodule

//--- divr_top_test.sv
// Bench for the vectoring block: both variants side by side.
// Assumes the package, design and sequencer model compile first.
`timescale 1ns/1ns
module divr_top_test;
   import divr_pkg::*;
   typedef struct packed
   {
      logic [3:0] pin;
      logic [7:0] req;
      logic [7:0] msk;
      logic [13:0] hv;
      logic [13:0] dv;
   } divr_row_s;
   // Pin field: request two low, alt config, frame sync rx, frame sync tx
   divr_row_s rows [12] = '{
      '{4'h3, 8'h00, 8'hFF, 14'h0004, 14'h0004},
      '{4'hB, 8'h86, 8'hFF, 14'h0008, 14'h0018},
      '{4'hB, 8'h84, 8'hFF, 14'h000C, 14'h0018},
      '{4'hB, 8'h08, 8'hFF, 14'h0010, 14'h0008},
      '{4'hB, 8'h10, 8'hFF, 14'h0014, 14'h000C},
      '{4'hB, 8'h20, 8'hFF, 14'h0018, 14'h0010},
      '{4'hB, 8'h40, 8'hFF, 14'h001C, 14'h0014},
      '{4'hB, 8'h80, 8'hFF, 14'h0020, 14'h0018},
      '{4'hB, 8'hF8, 8'hF0, 14'h0014, 14'h0014},
      '{4'h3, 8'hFF, 8'h7E, 14'h0008, 14'h0008},
      '{4'hD, 8'h00, 8'hFF, 14'h001C, 14'h0014},
      '{4'hE, 8'h00, 8'hFF, 14'h0018, 14'h0010}};
   logic clk_i, sys_rst_i, alt_cfg_i, ext_req_two_n_i, p1_rfs_i, p1_tfs_i;
   logic p1_drx_i, p1_dtx_port_i, flag_out_i, mask_we_i, ctl_we_i, rti_i;
   logic mode_stat_we_i, ack_h, ack_d, pend_d;
   logic [7:0] periph_req_i, mask_wr_i, mask_o, n_h, n_d;
   logic [4:0] ctl_wr_i;
   logic [15:0] arith_stat_i, mode_stat_wr_i, mode_stat_o, arith_pop_o;
   logic irq_pend_o, stack_empty_o, stack_full_o, p1_dtx_o, flag_in_o;
   logic clk_out_o;
   logic [13:0] vector_o, vec_d, tv_h, tv_d;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   divr_top #(.HOST_VARIANT(1'b1)) uut (.*, .ack_i(ack_h));
   divr_top #(.HOST_VARIANT(1'b0)) uut_dual (.*, .ack_i(ack_d),
      .irq_pend_o(pend_d), .vector_o(vec_d), .mask_o(), .mode_stat_o(),
      .arith_pop_o(), .stack_empty_o(), .stack_full_o(), .p1_dtx_o(),
      .flag_in_o(), .clk_out_o());
   // The fast sequencer answers at once, the slow one waits three cycles
   divr_seq_model seq_h (.clk_i, .sys_rst_i, .pend_i(irq_pend_o),
      .vec_i(vector_o), .lat_i(2'h0), .ack_o(ack_h), .vec_o(tv_h),
      .cnt_o(n_h));
   divr_seq_model seq_d (.clk_i, .sys_rst_i, .pend_i(pend_d),
      .vec_i(vec_d), .lat_i(2'h3), .ack_o(ack_d), .vec_o(tv_d),
      .cnt_o(n_d));
   // **************************************************
   // Clock, timeout and checks
   // **************************************************
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic complete_run();
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         complete_run();
      end
   end
   task automatic chk_bit(input logic a, input logic e);
      checks_done++;
      if (a !== e)
      begin
         mismatches++;
         $display("[ERR] %0t flag %b want %b", $time, a, e);
      end
   endtask
   task automatic chk_vec(input logic [13:0] a, input logic [13:0] e);
      checks_done++;
      if (a !== e)
      begin
         mismatches++;
         $display("[ERR] %0t vector %h want %h", $time, a, e);
      end
   endtask
   task automatic chk_word(input logic [15:0] a, input logic [15:0] e);
      checks_done++;
      if (a !== e)
      begin
         mismatches++;
         $display("[ERR] %0t word %h want %h", $time, a, e);
      end
   endtask
   task automatic set_regs(input logic [7:0] m, input logic [15:0] s);
      @(posedge clk_i);
      mask_wr_i <= m;
      mode_stat_wr_i <= s;
      mask_we_i <= 1'b1;
      mode_stat_we_i <= 1'b1;
      @(posedge clk_i);
      mask_we_i <= 1'b0;
      mode_stat_we_i <= 1'b0;
   endtask
   task automatic set_ctl(input logic [4:0] c);
      @(posedge clk_i);
      ctl_wr_i <= c;
      ctl_we_i <= 1'b1;
      @(posedge clk_i);
      ctl_we_i <= 1'b0;
   endtask
   task automatic do_rti(input int n);
      repeat (n)
      begin
         @(posedge clk_i);
         rti_i <= 1'b1;
         @(posedge clk_i);
         rti_i <= 1'b0;
      end
      @(posedge clk_i);
      #1;
   endtask
   task automatic wait_acks(input logic [7:0] h, input logic [7:0] d);
      int k;
      k = 0;
      while ((n_h < h || n_d < d) && k < 200)
      begin
         @(posedge clk_i);
         k++;
      end
      #1;
      chk_bit(k < 200, 1'b1);
   endtask
   // **************************************************
   // Stimulus
   // **************************************************
   initial
   begin
      logic [7:0] base;
      logic c;
      {alt_cfg_i, p1_drx_i, p1_dtx_port_i, flag_out_i, mask_we_i} = '0;
      {ctl_we_i, rti_i, mode_stat_we_i} = '0;
      {ext_req_two_n_i, p1_rfs_i, p1_tfs_i, sys_rst_i} = 4'hF;
      {periph_req_i, mask_wr_i, ctl_wr_i} = '0;
      {arith_stat_i, mode_stat_wr_i} = '0;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      foreach (rows[i])
      begin
         set_regs(rows[i].msk, 16'h0000);
         @(posedge clk_i);
         {ext_req_two_n_i, alt_cfg_i, p1_rfs_i, p1_tfs_i} <= rows[i].pin;
         periph_req_i <= rows[i].req;
         wait_acks(n_h + 8'h01, n_d + 8'h01);
         chk_vec(tv_h, rows[i].hv);
         chk_vec(tv_d, rows[i].dv);
         {ext_req_two_n_i, alt_cfg_i, p1_rfs_i, p1_tfs_i} <= 4'hB;
         periph_req_i <= 8'h00;
         do_rti(1);
         chk_bit(stack_empty_o, 1'b1);
      end
      // Saved state returns on pop even after being overwritten
      // Mask keeps host timer, dual timer and host write slots open
      set_regs(8'hA2, 16'h1234);
      arith_stat_i <= 16'hA5C3;
      periph_req_i <= 8'h80;
      wait_acks(n_h + 8'h01, n_d + 8'h01);
      periph_req_i <= 8'h00;
      set_regs(8'h01, 16'h0000);
      do_rti(1);
      chk_word({8'h00, mask_o}, 16'h00A2);
      chk_word(mode_stat_o, 16'h1234);
      chk_word(arith_pop_o, 16'hA5C3);
      // Nested takes of a held request fill the stack at nine
      set_ctl(5'h10);
      base = n_h;
      periph_req_i <= 8'h80;
      wait_acks(base + 8'h09, 8'h00);
      repeat (6) @(posedge clk_i);
      #1;
      chk_word({8'h00, n_h}, {8'h00, base + 8'h09});
      chk_bit(stack_full_o, 1'b1);
      chk_bit(irq_pend_o, 1'b0);
      periph_req_i <= 8'h00;
      do_rti(10);
      chk_bit(stack_empty_o, 1'b1);
      // Without nesting a higher request waits; setting the nest bit lets it in
      set_ctl(5'h00);
      periph_req_i <= 8'h80;
      wait_acks(n_h + 8'h01, n_d + 8'h01);
      periph_req_i <= 8'h82;
      repeat (8) @(posedge clk_i);
      #1;
      chk_bit(irq_pend_o, 1'b0);
      periph_req_i <= 8'h02;
      set_ctl(5'h10);
      wait_acks(n_h + 8'h01, 8'h00);
      chk_vec(tv_h, 14'h0008);
      periph_req_i <= 8'h00;
      do_rti(10);
      chk_bit(stack_empty_o, 1'b1);
      set_regs(8'hFF, 16'h00FF);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         alt_cfg_i <= i[1];
         {p1_rfs_i, p1_tfs_i} <= {2{i[1]}};
         {p1_drx_i, flag_out_i, p1_dtx_port_i} <= {i[0], i[0], ~i[0]};
         repeat (3) @(posedge clk_i);
         #1;
         chk_bit(p1_dtx_o, i[1] ? i[0] : ~i[0]);
         chk_bit(irq_pend_o, 1'b0);
         if (i[1])
            chk_bit(flag_in_o, i[0]);
      end
      // Reset while a routine is active
      periph_req_i <= 8'h80;
      wait_acks(n_h + 8'h01, n_d + 8'h01);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      c = clk_out_o;
      @(posedge clk_i);
      #1;
      chk_bit(clk_out_o, ~c);
      chk_word({8'h00, mask_o}, 16'h0000);
      chk_word(mode_stat_o, 16'h0000);
      chk_bit(stack_empty_o, 1'b1);
      chk_vec(vector_o, 14'h0000);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      chk_bit(irq_pend_o, 1'b0);
      complete_run();
   end
endmodule
